// File: core/mfl_filter.sv
// ipv6 multicast type classifier with global filter enable responder
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// What this block does
// - with filter bit 4 set listener discovery frames are forwarded, else dropped.
// - listener discovery needs destination mac 33:33:00:00:00:01.
// - both classes need ethertype 0x86DD.
// - both classes need ipv6 next header 58.
// - listener discovery needs icmpv6 type 130, 131 or 132.
// - with filter bit 5 set neighbor solicitation frames are forwarded, else dropped.
// - solicitation needs mac prefix 33:33:FF and ignores the last three mac bytes.
// - solicitation needs icmpv6 type 135.
// - a class matches only when all its tests pass together.
// - every good enable command is accepted; it is answered only when no answer is being sent or launched.
// - the answer carries packet type 0x92.
// - the answer has header 0-15, codes 16-19, checksum 20-23, pad to 45.
// - only generic reason values appear in the answer.
// ----------------------------------------------------------------------------
module mfl_filter
  import mfl_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire mfl_beat_type rx_i,
  input  wire logic [31:0]  filter_i,
  input  wire logic         cmd_valid_i,
  input  wire logic         cmd_csum_err_i,
  input  wire logic         cmd_id_err_i,
  input  wire logic [127:0] cmd_hdr_i,
  output mfl_verdict_type   verdict_o,
  output logic              filt_en_o,
  output mfl_beat_type      rsp_o,
  output logic              rsp_busy_o
);

  // ----------------------------------------------------------------------------
  // header capture
  // ----------------------------------------------------------------------------
  logic [7:0]  pos_q;
  logic [47:0] dmac_q;
  logic [15:0] etype_q;
  logic [7:0]  nxt_q;
  logic [7:0]  icmp_q;
  logic        short_q;
  logic [7:0]  pos_now;

  assign pos_now = rx_i.first ? 8'h00 : pos_q;

  // byte counter and field capture
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pos_q   <= 8'h00;
      dmac_q  <= 48'h0;
      etype_q <= 16'h0000;
      nxt_q   <= 8'h00;
      icmp_q  <= 8'h00;
      short_q <= 1'b1;
    end else if (rx_i.valid) begin
      if (pos_now != 8'hFF) begin
        pos_q <= pos_now + 8'h01;
      end
      if (rx_i.first) begin
        short_q <= 1'b1;
      end
      if (pos_now < 8'h06) begin
        dmac_q <= {dmac_q[39:0], rx_i.data};
      end
      if (pos_now == 8'(MFL_ETYPE_HI_POS)) begin
        etype_q[15:8] <= rx_i.data;
      end
      if (pos_now == 8'(MFL_ETYPE_LO_POS)) begin
        etype_q[7:0] <= rx_i.data;
      end
      if (pos_now == 8'(MFL_NXTHDR_POS)) begin
        nxt_q <= rx_i.data;
      end
      if (pos_now == 8'(MFL_ICMP_TYPE_POS)) begin
        icmp_q  <= rx_i.data;
        short_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // classification at end of frame
  // ----------------------------------------------------------------------------
  logic ipv6_icmp;
  logic is_listener;
  logic is_solicit;
  logic [7:0] icmp_now;
  logic       full_now;

  // the icmp type may arrive on the last byte itself
  assign icmp_now = (pos_now == 8'(MFL_ICMP_TYPE_POS)) ? rx_i.data : icmp_q;
  assign full_now = !short_q || (pos_now == 8'(MFL_HDR_LAST_POS));

  assign ipv6_icmp = (etype_q == MFL_ETYPE_IPV6)
                   && (nxt_q == MFL_PROTO_ICMPV6);
  assign is_listener = full_now && ipv6_icmp
                     && (dmac_q == MFL_ALLNODES_MAC)
                     && ((icmp_now == MFL_ICMP_QUERY)
                      || (icmp_now == MFL_ICMP_REPORT)
                      || (icmp_now == MFL_ICMP_DONE));
  assign is_solicit = full_now && ipv6_icmp
                    && (dmac_q[47:24] == MFL_SOLICIT_PREFIX)
                    && (icmp_now == MFL_ICMP_SOLICIT);

  // verdict, only bits 4 and 5 of the filter field are looked at
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      verdict_o <= '0;
    end else begin
      verdict_o.valid    <= rx_i.valid && rx_i.last;
      verdict_o.listener <= is_listener;
      verdict_o.solicit  <= is_solicit;
      verdict_o.forward  <= (is_listener && filter_i[MFL_BIT_LISTENER])
                         || (is_solicit && filter_i[MFL_BIT_SOLICIT]);
    end
  end

  // ----------------------------------------------------------------------------
  // enable global multicast filter command
  // ----------------------------------------------------------------------------
  logic cmd_good;
  logic start_q;

  assign cmd_good = cmd_valid_i && !cmd_csum_err_i && !cmd_id_err_i;

  // accept every good command, launch answer only when not busy and not already starting
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      filt_en_o <= 1'b0;
      start_q   <= 1'b0;
    end else begin
      start_q <= cmd_good && !rsp_busy_o && !start_q;
      if (cmd_good) begin
        filt_en_o <= 1'b1;
      end
    end
  end

  mfl_rsp_gen u_rsp (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (start_q),
    .hdr_i     (cmd_hdr_i),
    .reason_i  (MFL_REASON_NONE),
    .beat_o    (rsp_o),
    .busy_o    (rsp_busy_o)
  );

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  property p_listener_fwd;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_i.valid && rx_i.last && is_listener && filter_i[MFL_BIT_LISTENER])
      |=> verdict_o.valid && verdict_o.forward;
  endproperty
  a_listener_fwd: assert property (p_listener_fwd) else $error("listener frame not forwarded");

  property p_listener_drop;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_i.valid && rx_i.last && !filter_i[MFL_BIT_LISTENER] && !is_solicit)
      |=> !verdict_o.forward;
  endproperty
  a_listener_drop: assert property (p_listener_drop) else $error("listener frame not dropped");

  property p_mac_listener;
    @(posedge sys_clk_i) disable iff (rst_i)
      is_listener |-> dmac_q == MFL_ALLNODES_MAC;
  endproperty
  a_mac_listener: assert property (p_mac_listener) else $error("listener mac mismatch");

  property p_etype;
    @(posedge sys_clk_i) disable iff (rst_i)
      (is_listener || is_solicit) |-> etype_q == MFL_ETYPE_IPV6 && nxt_q == MFL_PROTO_ICMPV6;
  endproperty
  a_etype: assert property (p_etype) else $error("ethertype or protocol mismatch");

  property p_solicit_fwd;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_i.valid && rx_i.last && is_solicit) |=> verdict_o.forward == $past(filter_i[5]);
  endproperty
  a_solicit_fwd: assert property (p_solicit_fwd) else $error("solicit verdict wrong");

  property p_solicit_type;
    @(posedge sys_clk_i) disable iff (rst_i)
      is_solicit |-> icmp_now == MFL_ICMP_SOLICIT && dmac_q[47:24] == MFL_SOLICIT_PREFIX;
  endproperty
  a_solicit_type: assert property (p_solicit_type) else $error("solicit type mismatch");

  sequence s_rsp_start;
    ##[1:3] rsp_o.valid && rsp_o.first;
  endsequence
  property p_answer;
    @(posedge sys_clk_i) disable iff (rst_i)
      (cmd_good && !rsp_busy_o && !start_q) |-> s_rsp_start;
  endproperty
  a_answer: assert property (p_answer) else $error("good command not answered");

  property p_type_byte;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rsp_o.valid && rsp_o.first) |-> ##4 rsp_o.data == MFL_RSP_TYPE;
  endproperty
  a_type_byte: assert property (p_type_byte) else $error("response type byte wrong");

  property p_length;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rsp_o.valid && rsp_o.first) |-> ##45 rsp_o.valid && rsp_o.last;
  endproperty
  a_length: assert property (p_length) else $error("response length wrong");

  property p_no_answer;
    @(posedge sys_clk_i) disable iff (rst_i)
      (cmd_valid_i && (cmd_csum_err_i || cmd_id_err_i) && !rsp_busy_o && !start_q)
      |=> !start_q;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("bad command answered");

endmodule
`default_nettype wire

// File: core/mfl_pkg.sv
// shared constants and types for the ipv6 multicast type filter
package mfl_pkg;

  // frame byte positions (destination mac at byte 0)
  localparam int unsigned MFL_ETYPE_HI_POS   = 12;
  localparam int unsigned MFL_ETYPE_LO_POS   = 13;
  localparam int unsigned MFL_NXTHDR_POS     = 20;
  localparam int unsigned MFL_ICMP_TYPE_POS  = 54;
  localparam int unsigned MFL_HDR_LAST_POS   = 54;

  // match values
  localparam logic [47:0] MFL_ALLNODES_MAC   = 48'h3333_0000_0001;
  localparam logic [23:0] MFL_SOLICIT_PREFIX = 24'h3333FF;
  localparam logic [15:0] MFL_ETYPE_IPV6     = 16'h86DD;
  localparam logic [7:0]  MFL_PROTO_ICMPV6   = 8'h3A;
  localparam logic [7:0]  MFL_ICMP_QUERY     = 8'h82;
  localparam logic [7:0]  MFL_ICMP_REPORT    = 8'h83;
  localparam logic [7:0]  MFL_ICMP_DONE      = 8'h84;
  localparam logic [7:0]  MFL_ICMP_SOLICIT   = 8'h87;

  // filter field bit positions
  localparam int unsigned MFL_BIT_LISTENER   = 4;
  localparam int unsigned MFL_BIT_SOLICIT    = 5;
  localparam logic [31:0] MFL_FILTER_RST     = 32'h0000_0000;

  // response packet layout
  localparam logic [7:0]  MFL_RSP_TYPE       = 8'h92;
  localparam logic [5:0]  MFL_RSP_HDR_LAST   = 6'h0F;
  localparam logic [5:0]  MFL_RSP_CODE_FIRST = 6'h10;
  localparam logic [5:0]  MFL_RSP_CSUM_FIRST = 6'h14;
  localparam logic [5:0]  MFL_RSP_PAD_FIRST  = 6'h18;
  localparam logic [5:0]  MFL_RSP_LAST       = 6'h2D;
  localparam logic [5:0]  MFL_RSP_TYPE_POS   = 6'h04;
  localparam logic [15:0] MFL_RSP_COMPLETED  = 16'h0000;
  localparam logic [15:0] MFL_REASON_NONE    = 16'h0000;

  // one byte beat of a frame
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } mfl_beat_type;

  // verdict of a classified frame
  typedef struct packed {
    logic valid;
    logic forward;
    logic listener;
    logic solicit;
  } mfl_verdict_type;

  typedef enum logic [2:0] {
    MFL_RSP_IDLE = 3'b001,
    MFL_RSP_SEND = 3'b010,
    MFL_RSP_DONE = 3'b100
  } mfl_rsp_state_type;

endpackage

// File: core/mfl_rsp_gen.sv
// response packet byte generator for the enable global multicast filter command
`timescale 1ns/1ps
`default_nettype none
module mfl_rsp_gen
  import mfl_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [127:0] hdr_i,
  input  wire logic [15:0]  reason_i,
  output mfl_beat_type      beat_o,
  output logic              busy_o
);

  mfl_rsp_state_type state_q;
  logic [5:0]        idx_q;
  logic [31:0]       csum_q;
  logic [7:0]        byte_d;
  logic [15:0]       word_d;

  // byte selection by position within the 46 byte packet
  always_comb begin
    byte_d = 8'h00;
    word_d = 16'h0000;
    if (idx_q <= MFL_RSP_HDR_LAST) begin
      byte_d = hdr_i[8'(127 - 8 * idx_q) -: 8];
      if (idx_q == MFL_RSP_TYPE_POS) begin
        byte_d = MFL_RSP_TYPE;
      end
    end else if (idx_q < MFL_RSP_CSUM_FIRST) begin
      // only the generic reason value is ever sent
      word_d = (idx_q < 6'h12) ? MFL_RSP_COMPLETED : reason_i;
      byte_d = idx_q[0] ? word_d[7:0] : word_d[15:8];
    end else if (idx_q < MFL_RSP_PAD_FIRST) begin
      byte_d = csum_q[8'(31 - 8 * (idx_q - MFL_RSP_CSUM_FIRST)) -: 8];
    end
  end

  // packet walker
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= MFL_RSP_IDLE;
      idx_q   <= 6'h00;
      csum_q  <= 32'h0000_0000;
      beat_o  <= '0;
    end else begin
      unique case (state_q)
        MFL_RSP_IDLE: begin
          beat_o <= '0;
          idx_q  <= 6'h00;
          csum_q <= 32'h0000_0000;
          if (start_i) begin
            state_q <= MFL_RSP_SEND;
          end
        end
        MFL_RSP_SEND: begin
          beat_o <= '{valid: 1'b1, first: (idx_q == 6'h00),
                      last: (idx_q == MFL_RSP_LAST), data: byte_d};
          // running negated sum of header and codes, emitted as is
          if (idx_q < MFL_RSP_CSUM_FIRST) begin
            csum_q <= csum_q - {24'h000000, byte_d};
          end
          idx_q <= idx_q + 6'h01;
          if (idx_q == MFL_RSP_LAST) begin
            state_q <= MFL_RSP_DONE;
          end
        end
        MFL_RSP_DONE: begin
          beat_o  <= '0;
          state_q <= MFL_RSP_IDLE;
        end
        default: begin
          state_q <= MFL_RSP_IDLE;
        end
      endcase
    end
  end

  // busy flag registered, tracks the next state so it matches a not-idle decode
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (state_q == MFL_RSP_IDLE) begin
      busy_o <= start_i;
    end else begin
      busy_o <= (state_q != MFL_RSP_DONE);
    end
  end

endmodule
`default_nettype wire

// File: verif/mfl_mc_model.sv
// management controller stand-in: sends commands and collects answers
`timescale 1ns/1ps
`default_nettype none
module mfl_mc_model
  import mfl_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire mfl_beat_type rsp_i,
  output logic              cmd_valid_o,
  output logic              csum_err_o,
  output logic              id_err_o,
  output logic [127:0]      hdr_o
);
  logic [7:0] got_q [46];
  int         cnt_q;
  int         bad_q;

  // idle levels; header held stable through every answer
  initial begin
    cmd_valid_o = 1'b0;
    csum_err_o  = 1'b0;
    id_err_o    = 1'b0;
    hdr_o       = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    cnt_q       = 0;
    bad_q       = 0;
  end

  // one command pulse; per-address filters are not used here
  task automatic send(input logic ce, input logic ie);
    @(posedge sys_clk_i);
    #1;
    cnt_q       = 0;
    cmd_valid_o = 1'b1;
    csum_err_o  = ce;
    id_err_o    = ie;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_o = 1'b0;
    csum_err_o  = 1'b0;
    id_err_o    = 1'b0;
  endtask

  // capture answer bytes, count misplaced frame marks
  always @(posedge sys_clk_i) begin
    if (rsp_i.valid === 1'b1) begin
      if (cnt_q < 46) got_q[cnt_q] = rsp_i.data;
      if (rsp_i.first !== (cnt_q == 0) || rsp_i.last !== (cnt_q == 45)) bad_q++;
      cnt_q++;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the ipv6 multicast type filter
`timescale 1ns/1ps
`default_nettype none
module tb
  import mfl_pkg::*;
;
  logic            sys_clk_i;
  logic            rst_i;
  mfl_beat_type    rx_i;
  logic [31:0]     filter_i;
  logic            cmd_valid_i;
  logic            cmd_csum_err_i;
  logic            cmd_id_err_i;
  logic [127:0]    cmd_hdr_i;
  mfl_verdict_type verdict_o;
  logic            filt_en_o;
  mfl_beat_type    rsp_o;
  logic            rsp_busy_o;
  int              fails;
  int              checks_done;
  localparam logic [47:0] AN = 48'h3333_0000_0001;
  localparam logic [47:0] SN = 48'h3333_FF12_3456;

  mfl_filter mfl_filter_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .rx_i(rx_i),
    .filter_i(filter_i), .cmd_valid_i(cmd_valid_i), .cmd_csum_err_i(cmd_csum_err_i),
    .cmd_id_err_i(cmd_id_err_i), .cmd_hdr_i(cmd_hdr_i), .verdict_o(verdict_o),
    .filt_en_o(filt_en_o), .rsp_o(rsp_o), .rsp_busy_o(rsp_busy_o));
  mfl_mc_model mfl_mc_model_i (.sys_clk_i(sys_clk_i), .rsp_i(rsp_o),
    .cmd_valid_o(cmd_valid_i), .csum_err_o(cmd_csum_err_i), .id_err_o(cmd_id_err_i),
    .hdr_o(cmd_hdr_i));

  // clock, 100 ns period
  initial sys_clk_i = 1'b0;
  always #50 sys_clk_i = ~sys_clk_i;

  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // drive one frame and judge whether it was forwarded
  task automatic frame(input logic [47:0] mac, input logic [15:0] et, input logic [7:0] nh,
                       input logic [7:0] ic, input int len, input logic [31:0] flt,
                       input logic fwd);
    logic [7:0] b;
    int         n;
    logic       lx;
    logic       sx;
    // expected class flags straight from the class definitions
    lx = (len > 54) && (mac == 48'h3333_0000_0001) && (et == 16'h86DD) && (nh == 8'h3A)
      && (ic == 8'h82 || ic == 8'h83 || ic == 8'h84);
    sx = (len > 54) && (mac[47:24] == 24'h3333FF) && (et == 16'h86DD) && (nh == 8'h3A)
      && (ic == 8'h87);
    filter_i = flt;
    for (int i = 0; i < len; i++) begin
      b = 8'h00;
      if (i < 6) b = mac[47-8*i -: 8];
      if (i == 12) b = et[15:8];
      if (i == 13) b = et[7:0];
      if (i == 20) b = nh;
      if (i == 54) b = ic;
      rx_i = '{1'b1, i == 0, i == len - 1, b};
      @(posedge sys_clk_i);
      #1;
    end
    rx_i = '0;
    n = 0;
    while (verdict_o.valid !== 1'b1 && n < 3) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk({31'h0, verdict_o.valid}, 32'h1);
    chk({31'h0, verdict_o.valid & verdict_o.forward}, {31'h0, fwd});
    chk({31'h0, verdict_o.listener}, {31'h0, lx});
    chk({31'h0, verdict_o.solicit}, {31'h0, sx});
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_listener;
    for (int t = 130; t <= 132; t++) frame(AN, 16'h86DD, 8'h3A, 8'(t), 60, 32'h10, 1);
    frame(AN, 16'h86DD, 8'h3A, 8'h82, 60, 32'h00, 0);
    frame(AN, 16'h86DD, 8'h3A, 8'h85, 60, 32'h30, 0);
    frame(AN ^ 48'h3, 16'h86DD, 8'h3A, 8'h83, 60, 32'h30, 0);
    frame(AN, 16'h0800, 8'h3A, 8'h84, 60, 32'h30, 0);
    frame(AN, 16'h86DD, 8'h11, 8'h82, 60, 32'h30, 0);
    frame(AN, 16'h86DD, 8'h3A, 8'h82, 54, 32'h30, 0);
  endtask

  task automatic t_solicit;
    frame(SN, 16'h86DD, 8'h3A, 8'h87, 60, 32'h20, 1);
    frame(48'h3333_FFAB_CDEF, 16'h86DD, 8'h3A, 8'h87, 60, 32'h20, 1);
    frame(SN, 16'h86DD, 8'h3A, 8'h87, 60, 32'h10, 0);
    frame(48'h3333_FE12_3456, 16'h86DD, 8'h3A, 8'h87, 60, 32'h30, 0);
    frame(SN, 16'h86DD, 8'h3A, 8'h88, 60, 32'h30, 0);
    frame(SN, 16'h0800, 8'h3A, 8'h87, 60, 32'h30, 0);
    frame(SN, 16'h86DD, 8'h06, 8'h87, 60, 32'h30, 0);
    frame(SN, 16'h86DD, 8'h3A, 8'h82, 60, 32'h30, 0);
    frame(AN, 16'h86DD, 8'h3A, 8'h87, 60, 32'h30, 0);
  endtask

  task automatic t_reserved;
    frame(AN, 16'h86DD, 8'h3A, 8'h82, 60, 32'hFFFF_FFCF, 0);
    frame(SN, 16'h86DD, 8'h3A, 8'h87, 60, 32'hFFFF_FFCF, 0);
    frame(SN, 16'h86DD, 8'h3A, 8'h87, 60, 32'hFFFF_FFFF, 1);
  endtask

  task automatic t_cmd_err;
    mfl_mc_model_i.send(1'b1, 1'b0);
    repeat (60) @(posedge sys_clk_i);
    #1;
    chk(mfl_mc_model_i.cnt_q, 0);
    mfl_mc_model_i.send(1'b0, 1'b1);
    repeat (60) @(posedge sys_clk_i);
    #1;
    chk(mfl_mc_model_i.cnt_q, 0);
    chk({31'h0, filt_en_o}, 0);
  endtask

  task automatic t_cmd_ok;
    logic [7:0]  e [46];
    logic [31:0] s;
    for (int k = 0; k < 2; k++) begin
      mfl_mc_model_i.send(1'b0, 1'b0);
      repeat (60) @(posedge sys_clk_i);
      #1;
      chk({31'h0, filt_en_o}, 1);
      chk(mfl_mc_model_i.cnt_q, 46);
      chk(mfl_mc_model_i.bad_q, 0);
      s = 32'h0;
      for (int i = 0; i < 46; i++) begin
        e[i] = (i < 16) ? cmd_hdr_i[127-8*i -: 8] : 8'h00;
        if (i == 4) e[i] = 8'h92;
        if (i < 20) s = s + 32'(e[i]);
      end
      s = -s;
      for (int i = 0; i < 4; i++) e[20+i] = s[31-8*i -: 8];
      for (int i = 0; i < 46; i++) chk(32'(mfl_mc_model_i.got_q[i]), 32'(e[i]));
    end
  endtask

  // main sequence after reset of 8 cycles
  initial begin
    fails       = 0;
    checks_done = 0;
    rst_i       = 1'b1;
    rx_i        = '0;
    filter_i    = 32'h0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    chk({29'h0, rsp_busy_o, filt_en_o, verdict_o.valid}, 0);
    t_listener();
    t_solicit();
    t_reserved();
    t_cmd_err();
    t_cmd_ok();
    complete_run();
  end

  // watchdog well beyond the expected run
  initial begin
    #1ms;
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
